// >>> hdl/bfx_exec.sv
// execute unit for bit, flag, shift, branch-on-interrupt-flag and move operations
`timescale 1ns/1ps
//
// Operation
// (RL1) branch when interrupts on: pc+k+1, 1/2 cycles
// (RL2) branch when interrupts off: pc+k+1, flags kept
// (RL3) io bit set, two cycles, flags kept
// (RL4) io bit clear, two cycles, flags kept
// (RL5) shift left, zero in, ZCNV in one cycle
// (RL6) shift right, zero in, ZCNV in one cycle
// (RL7) rotate left through carry, ZCNV, one cycle
// (RL8) rotate right / arithmetic right, ZCNV, one cycle
// (RL9) nibble swap, one cycle, flags kept
// (RL10) set/clear status bit by index, one cycle
// (RL11) clear half carry only, one cycle
// (RL12) set/clear signed flag only, one cycle
// (RL13) set/clear overflow flag, one cycle
// (RL14) copy register bit into transfer flag
// (RL15) copy transfer flag into register bit
// (RL16) global interrupt on/off touches only that flag
// (RL17) moves one cycle, indirect load two cycles
module bfx_exec
    import bfx_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic OP_VALID,
    input wire logic [4:0] OP_CODE,
    input wire logic [4:0] OP_RD,
    input wire logic [4:0] OP_RR,
    input wire logic [7:0] OP_IMM,
    input wire logic [6:0] OP_OFFSET,
    input wire logic [2:0] OP_BIT,
    input wire logic [4:0] OP_IO_ADDR,
    input wire logic MEM_LOAD_EN,
    input wire logic [9:0] MEM_LOAD_ADDR,
    input wire logic [7:0] MEM_LOAD_DATA,
    input wire logic IO_LOAD_EN,
    input wire logic [4:0] IO_LOAD_ADDR,
    input wire logic [7:0] IO_LOAD_DATA,
    input wire logic [4:0] DBG_REG_SEL,
    output logic OP_READY,
    output logic [15:0] PC_OUT,
    output logic [7:0] STATUS_REGISTER_OUT,
    output logic IO_WR_STB,
    output logic [4:0] IO_WR_ADDR,
    output logic [7:0] IO_WR_DATA,
    output logic [7:0] DBG_REG_DATA
);

    typedef struct packed {
        logic [REG_COUNT-1:0][7:0] regs;
        logic [7:0] status_register;
        logic [PC_W-1:0] pc;
        bfx_phase_t phase;
        logic [4:0] pend_op;
        logic [4:0] pend_rd;
        logic [2:0] pend_bit;
        logic [4:0] pend_io;
        logic ready;
        logic io_stb;
        logic [4:0] io_addr;
        logic [7:0] io_data;
        logic [7:0] dbg;
    } bfx_state_t;

    bfx_state_t s_r;
    bfx_state_t s_nxt;

    logic [7:0] io_rd_data;
    logic [7:0] dm_rd_data;
    logic io_we;
    logic [4:0] io_waddr;
    logic [7:0] io_wdata;
    logic [7:0] io_mod;
    logic [DM_AW-1:0] dm_raddr;
    logic [15:0] ptr_word;

    ////////////////////////////////////////////////////////////////////////////////////
    // memories: io space and data space, both read one cycle after the address

    // second cycle of a bit op writes back; preload only gets the port otherwise
    always_comb begin
        io_mod = io_rd_data;
        io_mod[s_r.pend_bit] = (s_r.pend_op == OP_SET_IO_BIT); // see (RL3) see (RL4)
        io_we = IO_LOAD_EN;
        io_waddr = IO_LOAD_ADDR;
        io_wdata = IO_LOAD_DATA;
        if (s_r.phase == PH_SECOND && (s_r.pend_op == OP_SET_IO_BIT ||
                                       s_r.pend_op == OP_CLEAR_IO_BIT)) begin
            io_we = 1'b1;
            io_waddr = s_r.pend_io;
            io_wdata = io_mod;
        end
    end

    // data address from the first pointer pair, low bits only
    // the upper pointer bits fall outside the 1 KiB data space and are dropped on purpose
    assign ptr_word = {s_r.regs[PTR_HI_IDX], s_r.regs[PTR_LO_IDX]};
    assign dm_raddr = ptr_word[DM_AW-1:0];

    bfx_mem #(.AW(IO_AW), .DW(8)) u_io (
        .clk(MCLK),
        .wr_en(io_we),
        .wr_addr(io_waddr),
        .wr_data(io_wdata),
        .rd_addr(OP_IO_ADDR),
        .rd_data(io_rd_data)
    );

    bfx_mem #(.AW(DM_AW), .DW(8)) u_dm (
        .clk(MCLK),
        .wr_en(MEM_LOAD_EN),
        .wr_addr(MEM_LOAD_ADDR),
        .wr_data(MEM_LOAD_DATA),
        .rd_addr(dm_raddr),
        .rd_data(dm_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        logic [7:0] a;
        logic [7:0] res;
        logic cout;
        logic do_flags;
        logic [PC_W-1:0] k_ext;
        a = s_r.regs[OP_RD];
        res = a;
        cout = s_r.status_register[SR_C];
        do_flags = 1'b0;
        k_ext = {{(PC_W-7){OP_OFFSET[6]}}, OP_OFFSET};
        s_nxt = s_r;
        s_nxt.io_stb = 1'b0;
        s_nxt.dbg = s_r.regs[DBG_REG_SEL];

        if (s_r.phase == PH_SECOND) begin
            // second cycle: finish the pending two-cycle operation
            s_nxt.phase = PH_ISSUE;
            s_nxt.ready = 1'b1;
            if (s_r.pend_op == OP_LOAD_INDIRECT) begin
                s_nxt.regs[s_r.pend_rd] = dm_rd_data; // see (RL17)
            end else if (s_r.pend_op == OP_SET_IO_BIT || s_r.pend_op == OP_CLEAR_IO_BIT) begin
                s_nxt.io_stb = 1'b1; // see (RL3) see (RL4)
                s_nxt.io_addr = s_r.pend_io;
                s_nxt.io_data = io_mod;
            end
        end else if (OP_VALID) begin
            s_nxt.pc = s_r.pc + 16'h0001;
            s_nxt.pend_op = OP_CODE;
            s_nxt.pend_rd = OP_RD;
            s_nxt.pend_bit = OP_BIT;
            s_nxt.pend_io = OP_IO_ADDR;
            unique case (OP_CODE)
                OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF: begin
                    // taken branch costs a bubble cycle; flags are never written
                    if (s_r.status_register[SR_I] == (OP_CODE == OP_BRANCH_IRQ_ON)) begin
                        s_nxt.pc = s_r.pc + k_ext + 16'h0001; // see (RL1) see (RL2)
                        s_nxt.phase = PH_SECOND;
                        s_nxt.ready = 1'b0;
                    end
                end
                OP_SET_IO_BIT, OP_CLEAR_IO_BIT, OP_LOAD_INDIRECT: begin
                    s_nxt.phase = PH_SECOND; // see (RL3) see (RL4) see (RL17)
                    s_nxt.ready = 1'b0;
                end
                OP_SHIFT_LEFT_LOGICAL: begin
                    res = {a[6:0], 1'b0}; // see (RL5)
                    cout = a[7];
                    do_flags = 1'b1;
                end
                OP_SHIFT_RIGHT_LOGICAL: begin
                    res = {1'b0, a[7:1]}; // see (RL6)
                    cout = a[0];
                    do_flags = 1'b1;
                end
                OP_ROTATE_LEFT_CARRY: begin
                    res = {a[6:0], s_r.status_register[SR_C]}; // see (RL7)
                    cout = a[7];
                    do_flags = 1'b1;
                end
                OP_ROTATE_RIGHT_CARRY: begin
                    res = {s_r.status_register[SR_C], a[7:1]}; // see (RL8)
                    cout = a[0];
                    do_flags = 1'b1;
                end
                OP_SHIFT_RIGHT_ARITH: begin
                    res = {a[7], a[7:1]}; // see (RL8)
                    cout = a[0];
                    do_flags = 1'b1;
                end
                OP_SWAP_NIBBLES: begin
                    s_nxt.regs[OP_RD] = {a[3:0], a[7:4]}; // see (RL9)
                end
                // dedicated forms (carry, zero, half carry, signed, overflow, transfer,
                // global interrupt) arrive as these with the bit index filled in
                OP_FLAG_SET_BY_INDEX: begin
                    s_nxt.status_register[OP_BIT] = 1'b1; // see (RL10) see (RL12) see (RL13) see (RL16)
                end
                OP_FLAG_CLEAR_BY_INDEX: begin
                    s_nxt.status_register[OP_BIT] = 1'b0; // see (RL10) see (RL11) see (RL12) see (RL16)
                end
                OP_STORE_BIT_TO_T: begin
                    s_nxt.status_register[SR_T] = s_r.regs[OP_RR][OP_BIT]; // see (RL14)
                end
                OP_LOAD_BIT_FROM_T: begin
                    s_nxt.regs[OP_RD][OP_BIT] = s_r.status_register[SR_T]; // see (RL15)
                end
                OP_COPY_REGISTER: begin
                    s_nxt.regs[OP_RD] = s_r.regs[OP_RR]; // see (RL17)
                end
                OP_COPY_REGISTER_PAIR: begin
                    // pair indices use the even register; the low bit is ignored
                    s_nxt.regs[{OP_RD[4:1], 1'b0}] = s_r.regs[{OP_RR[4:1], 1'b0}]; // see (RL17)
                    s_nxt.regs[{OP_RD[4:1], 1'b1}] = s_r.regs[{OP_RR[4:1], 1'b1}];
                end
                OP_LOAD_IMMEDIATE_VALUE: begin
                    s_nxt.regs[OP_RD] = OP_IMM; // see (RL17)
                end
                default: begin
                    // unknown codes and the idle code just advance the counter
                end
            endcase
            // shift group: half carry, signed and the rest stay as they were
            if (do_flags) begin
                s_nxt.regs[OP_RD] = res;
                s_nxt.status_register[SR_C] = cout; // see (RL5) see (RL6) see (RL7) see (RL8)
                s_nxt.status_register[SR_Z] = (res == 8'h00);
                s_nxt.status_register[SR_N] = res[7];
                s_nxt.status_register[SR_V] = res[7] ^ cout;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s_r <= '{regs: '{default: REG_RST}, status_register: STATUS_REGISTER_RST, pc: PC_RST,
                     phase: PH_ISSUE, pend_op: 5'h00, pend_rd: 5'h00, pend_bit: 3'h0,
                     pend_io: 5'h00, ready: 1'b1, io_stb: 1'b0, io_addr: 5'h00,
                     io_data: 8'h00, dbg: 8'h00};
        end else begin
            s_r <= s_nxt;
        end
    end

    // all outputs straight from the state register
    assign OP_READY = s_r.ready;
    assign PC_OUT = s_r.pc;
    assign STATUS_REGISTER_OUT = s_r.status_register;
    assign IO_WR_STB = s_r.io_stb;
    assign IO_WR_ADDR = s_r.io_addr;
    assign IO_WR_DATA = s_r.io_data;
    assign DBG_REG_DATA = s_r.dbg;

endmodule

// >>> hdl/bfx_pkg.sv
// package with operation codes, status bit positions, widths and reset values
package bfx_pkg;

    // status register bit positions
    localparam int unsigned SR_C = 0;
    localparam int unsigned SR_Z = 1;
    localparam int unsigned SR_N = 2;
    localparam int unsigned SR_V = 3;
    localparam int unsigned SR_S = 4;
    localparam int unsigned SR_H = 5;
    localparam int unsigned SR_T = 6;
    localparam int unsigned SR_I = 7;

    // widths and sizes
    localparam int unsigned REG_COUNT = 32;
    localparam int unsigned IO_AW = 5;
    localparam int unsigned DM_AW = 10;
    localparam int unsigned PC_W = 16;

    // pointer pair used by the indirect load (low byte, high byte)
    localparam logic [4:0] PTR_LO_IDX = 5'h1A;
    localparam logic [4:0] PTR_HI_IDX = 5'h1B;

    // reset values
    localparam logic [7:0] STATUS_REGISTER_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] REG_RST = 8'h00;

    // decoded operations handed over by the decoder
    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_BRANCH_IRQ_ON = 5'h01,
        OP_BRANCH_IRQ_OFF = 5'h02,
        OP_SET_IO_BIT = 5'h03,
        OP_CLEAR_IO_BIT = 5'h04,
        OP_SHIFT_LEFT_LOGICAL = 5'h05,
        OP_SHIFT_RIGHT_LOGICAL = 5'h06,
        OP_ROTATE_LEFT_CARRY = 5'h07,
        OP_ROTATE_RIGHT_CARRY = 5'h08,
        OP_SHIFT_RIGHT_ARITH = 5'h09,
        OP_SWAP_NIBBLES = 5'h0A,
        OP_FLAG_SET_BY_INDEX = 5'h0B,
        OP_FLAG_CLEAR_BY_INDEX = 5'h0C,
        OP_STORE_BIT_TO_T = 5'h0D,
        OP_LOAD_BIT_FROM_T = 5'h0E,
        OP_COPY_REGISTER = 5'h0F,
        OP_COPY_REGISTER_PAIR = 5'h10,
        OP_LOAD_IMMEDIATE_VALUE = 5'h11,
        OP_LOAD_INDIRECT = 5'h12
    } bfx_op_t;

    typedef enum logic [0:0] {
        PH_ISSUE = 1'b0,
        PH_SECOND = 1'b1
    } bfx_phase_t;

endpackage

// >>> hdl/bfx_mem.sv
// small synchronous memory with registered read data
`timescale 1ns/1ps
module bfx_mem #(
    parameter int unsigned AW = 5,
    parameter int unsigned DW = 8
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // no reset on the array: contents are undefined until written
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// >>> sim/bfx_exec_sva.sv
// assertion checker for the bit, flag, shift and branch execute unit
`timescale 1ns/1ps
module bfx_exec_sva
    import bfx_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic OP_VALID,
    input wire logic [4:0] OP_CODE,
    input wire logic [6:0] OP_OFFSET,
    input wire logic [2:0] OP_BIT,
    input wire logic [4:0] OP_IO_ADDR,
    input wire logic OP_READY,
    input wire logic [15:0] PC_OUT,
    input wire logic [7:0] STATUS_REGISTER_OUT,
    input wire logic IO_WR_STB,
    input wire logic [4:0] IO_WR_ADDR,
    input wire logic [7:0] IO_WR_DATA
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    // qualifiers; an op offered while ready is low never counts
    wire logic take = OP_VALID && OP_READY;
    wire logic io_op = take && (OP_CODE == OP_SET_IO_BIT || OP_CODE == OP_CLEAR_IO_BIT);
    wire logic br_op = take && (OP_CODE == OP_BRANCH_IRQ_ON || OP_CODE == OP_BRANCH_IRQ_OFF);
    wire logic br_hit = br_op && ((OP_CODE == OP_BRANCH_IRQ_ON) == STATUS_REGISTER_OUT[SR_I]);
    ////////////////////////////////////////////////////////////////////////////////
    ready_gap_a: assert property (!OP_READY |=> OP_READY)
        else $error("ready low too long");
    branch_taken_a: assert property (br_hit |=> !OP_READY && PC_OUT ==
        $past(PC_OUT) + 16'($signed($past(OP_OFFSET))) + 16'h0001) else $error("bad jump");
    branch_skip_a: assert property (br_op && !br_hit |=> OP_READY
        && PC_OUT == $past(PC_OUT) + 16'h0001) else $error("bad fall through");
    io_strobe_a: assert property (io_op |=> !IO_WR_STB ##1 IO_WR_STB
        && IO_WR_ADDR == $past(OP_IO_ADDR, 2)) else $error("io strobe late");
    io_bit_a: assert property (io_op |=> ##1 IO_WR_DATA[$past(OP_BIT, 2)] ==
        ($past(OP_CODE, 2) == OP_SET_IO_BIT)) else $error("io bit wrong");
    flag_set_a: assert property (take && OP_CODE == OP_FLAG_SET_BY_INDEX |=>
        STATUS_REGISTER_OUT == ($past(STATUS_REGISTER_OUT) | (8'h01 << $past(OP_BIT)))) else $error("flag set");
    flag_clr_a: assert property (take && OP_CODE == OP_FLAG_CLEAR_BY_INDEX |=>
        STATUS_REGISTER_OUT == ($past(STATUS_REGISTER_OUT) & ~(8'h01 << $past(OP_BIT)))) else $error("flag clr");
    keep_flags_a: assert property (take && OP_CODE inside {OP_SWAP_NIBBLES,
        OP_LOAD_BIT_FROM_T, OP_COPY_REGISTER, OP_LOAD_IMMEDIATE_VALUE} |=> $stable(STATUS_REGISTER_OUT))
        else $error("flags moved");
    shift_flags_a: assert property (take && OP_CODE inside
        {[OP_SHIFT_LEFT_LOGICAL:OP_SHIFT_RIGHT_ARITH]} |=> STATUS_REGISTER_OUT[5:4] == $past(STATUS_REGISTER_OUT[5:4])
        && STATUS_REGISTER_OUT[SR_V] == (STATUS_REGISTER_OUT[SR_N] ^ STATUS_REGISTER_OUT[SR_C])) else $error("shift flags");
    cover property (br_hit);
    cover property (io_op);
    cover property (take && OP_CODE == OP_LOAD_INDIRECT);
endmodule
bind bfx_exec bfx_exec_sva chk (.MCLK(MCLK), .SYS_RST(SYS_RST), .OP_VALID(OP_VALID),
    .OP_CODE(OP_CODE), .OP_OFFSET(OP_OFFSET), .OP_BIT(OP_BIT), .OP_IO_ADDR(OP_IO_ADDR),
    .OP_READY(OP_READY), .PC_OUT(PC_OUT), .STATUS_REGISTER_OUT(STATUS_REGISTER_OUT), .IO_WR_STB(IO_WR_STB),
    .IO_WR_ADDR(IO_WR_ADDR), .IO_WR_DATA(IO_WR_DATA));

// >>> sim/bfx_dec_model.sv
// decoder model: presents one decoded op and holds it until it is taken
`timescale 1ns/1ps
module bfx_dec_model
    import bfx_pkg::*;
(
    input wire logic clk,
    input wire logic op_ready,
    output logic op_valid,
    output logic [4:0] op_code,
    output logic [4:0] op_rd,
    output logic [4:0] op_rr,
    output logic [7:0] op_imm,
    output logic [6:0] op_offset,
    output logic [2:0] op_bit,
    output logic [4:0] op_io_addr
);
    initial begin
        op_valid = 1'b0;
        {op_code, op_rd, op_rr, op_imm, op_offset, op_bit, op_io_addr} = '1;
    end
    // offset and bit index come from the value byte; idle fields flip so stale data shows
    task automatic send(input bfx_op_t c, input logic [4:0] d, input logic [4:0] s,
        input logic [7:0] v);
        logic r;
        @(posedge clk);
        #1;
        op_valid = 1'b1;
        {op_code, op_rd, op_rr, op_io_addr, op_imm} = {c, d, s, s, v};
        {op_offset, op_bit} = {v[6:0], v[2:0]};
        r = 1'b0;
        while (!r) begin
            r = op_ready;
            @(posedge clk);
            #1;
        end
        op_valid = 1'b0;
        {op_code, op_rd, op_rr, op_imm, op_offset, op_bit, op_io_addr} =
            ~{op_code, op_rd, op_rr, op_imm, op_offset, op_bit, op_io_addr};
    endtask
endmodule

// >>> sim/testbench.sv
// self-checking bench for the execute unit driven through the decoder model
`timescale 1ns/1ps
module testbench
    import bfx_pkg::*;
;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic mem_en = 1'b0;
    logic io_en = 1'b0;
    logic [4:0] dbg_sel = 5'h00;
    logic op_valid, op_ready, io_stb;
    logic [4:0] op_code, op_rd, op_rr, op_io, io_waddr;
    logic [7:0] op_imm, status_register, io_wdata, dbg_data, sx;
    logic [6:0] op_off;
    logic [2:0] op_bit;
    logic [15:0] pc, pcx;
    int err_total = 0;
    int checks_done = 0;
    // shift cases; carry out of one feeds the next
    bfx_op_t sh_op [6] = '{OP_SHIFT_LEFT_LOGICAL, OP_ROTATE_LEFT_CARRY, OP_SHIFT_RIGHT_ARITH,
        OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_RIGHT_CARRY, OP_ROTATE_LEFT_CARRY};
    logic [23:0] sh [6] = '{24'h810209, 24'h020500, 24'h80C00C, 24'h01000B, 24'h02810C,
        24'h80000B};
    always #5 mclk = ~mclk;
    bfx_dec_model dec (.clk(mclk), .op_ready(op_ready), .op_valid(op_valid), .op_code(op_code),
        .op_rd(op_rd), .op_rr(op_rr), .op_imm(op_imm), .op_offset(op_off), .op_bit(op_bit),
        .op_io_addr(op_io));
    bfx_exec dut (.MCLK(mclk), .SYS_RST(sys_rst), .OP_VALID(op_valid), .OP_CODE(op_code),
        .OP_RD(op_rd), .OP_RR(op_rr), .OP_IMM(op_imm), .OP_OFFSET(op_off), .OP_BIT(op_bit),
        .OP_IO_ADDR(op_io), .MEM_LOAD_EN(mem_en), .MEM_LOAD_ADDR(10'h123),
        .MEM_LOAD_DATA(8'hC3), .IO_LOAD_EN(io_en), .IO_LOAD_ADDR(5'h03), .IO_LOAD_DATA(8'h5A),
        .DBG_REG_SEL(dbg_sel), .OP_READY(op_ready), .PC_OUT(pc), .STATUS_REGISTER_OUT(status_register),
        .IO_WR_STB(io_stb), .IO_WR_ADDR(io_waddr), .IO_WR_DATA(io_wdata),
        .DBG_REG_DATA(dbg_data));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic op(input bfx_op_t c, input logic [4:0] d, input logic [4:0] s,
        input logic [7:0] v);
        dec.send(c, d, s, v);
        pcx = pcx + 16'h0001;
    endtask
    // debug view lags one edge, so wait two to see a second-cycle write
    task automatic reg_is(input logic [4:0] r, input logic [7:0] e);
        dbg_sel = r;
        repeat (2) @(posedge mclk);
        #1;
        cmp({8'h00, dbg_data}, {8'h00, e});
    endtask
    task automatic io_is(input logic [7:0] e);
        cmp({15'h0000, op_ready}, 16'h0000);
        @(posedge mclk);
        #1;
        cmp({2'b00, io_stb, io_waddr, io_wdata}, {8'h23, e});
        cmp({8'h00, status_register}, 16'h0000);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pcx = PC_RST;
        repeat (3) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        mem_en = 1'b1;
        io_en = 1'b1;
        @(posedge mclk);
        #1;
        mem_en = 1'b0;
        io_en = 1'b0;
        for (int i = 0; i < 6; i++) begin
            op(OP_LOAD_IMMEDIATE_VALUE, 5'h05, 5'h00, sh[i][23:16]);
            op(sh_op[i], 5'h05, 5'h00, 8'h00);
            cmp({8'h00, status_register}, {8'h00, sh[i][7:0]});
            reg_is(5'h05, sh[i][15:8]);
        end
        op(OP_LOAD_IMMEDIATE_VALUE, 5'h08, 5'h00, 8'hA5);
        op(OP_SWAP_NIBBLES, 5'h08, 5'h00, 8'h00);
        reg_is(5'h08, 8'h5A);
        // every status bit set, then all but the interrupt flag cleared
        sx = 8'h0B;
        for (int b = 0; b < 15; b++) begin
            sx[b % 8] = (b < 8);
            op(b < 8 ? OP_FLAG_SET_BY_INDEX : OP_FLAG_CLEAR_BY_INDEX, 5'h00, 5'h00, 8'(b % 8));
            cmp({8'h00, status_register}, {8'h00, sx});
        end
        op(OP_BRANCH_IRQ_ON, 5'h00, 5'h00, 8'h7E);
        pcx = pcx - 16'h0002;
        cmp({15'h0000, op_ready}, 16'h0000);
        cmp(pc, pcx);
        op(OP_BRANCH_IRQ_OFF, 5'h00, 5'h00, 8'h7E);
        cmp({15'h0000, op_ready}, 16'h0001);
        cmp(pc, pcx);
        op(OP_FLAG_CLEAR_BY_INDEX, 5'h00, 5'h00, 8'h07);
        op(OP_BRANCH_IRQ_OFF, 5'h00, 5'h00, 8'h3F);
        pcx = pcx + 16'h003F;
        cmp({15'h0000, op_ready}, 16'h0000);
        cmp(pc, pcx);
        op(OP_BRANCH_IRQ_ON, 5'h00, 5'h00, 8'h3F);
        cmp({8'h00, status_register}, 16'h0000);
        cmp(pc, pcx);
        op(OP_SET_IO_BIT, 5'h00, 5'h03, 8'h00);
        io_is(8'h5B);
        op(OP_CLEAR_IO_BIT, 5'h00, 5'h03, 8'h06);
        io_is(8'h1B);
        op(OP_LOAD_IMMEDIATE_VALUE, 5'h09, 5'h00, 8'h10);
        op(OP_STORE_BIT_TO_T, 5'h00, 5'h09, 8'h04);
        cmp({8'h00, status_register}, 16'h0040);
        op(OP_LOAD_BIT_FROM_T, 5'h0A, 5'h00, 8'h00);
        reg_is(5'h0A, 8'h01);
        op(OP_COPY_REGISTER, 5'h0B, 5'h09, 8'h00);
        reg_is(5'h0B, 8'h10);
        op(OP_COPY_REGISTER_PAIR, 5'h0C, 5'h08, 8'h00);
        reg_is(5'h0C, 8'h5A);
        reg_is(5'h0D, 8'h10);
        op(OP_LOAD_IMMEDIATE_VALUE, PTR_LO_IDX, 5'h00, 8'h23);
        op(OP_LOAD_IMMEDIATE_VALUE, PTR_HI_IDX, 5'h00, 8'h01);
        op(OP_LOAD_INDIRECT, 5'h0E, 5'h00, 8'h00);
        cmp({15'h0000, op_ready}, 16'h0000);
        cmp(pc, pcx);
        reg_is(5'h0E, 8'hC3);
        summarize();
    end
    // the sequence needs well under a thousand cycles
    initial begin
        #20000;
        err_total++;
        summarize();
    end
endmodule
